/* logic/sleep_mode_controller.sv */
`timescale 1ns/1ns
//Contract
// [RQ1] sleep needs enable bit plus halt instruction
// [RQ2] mode 000 enters idle
// [RQ3] mode 001 enters converter noise reduction
// [RQ4] interrupt wake holds core four extra cycles
// [RQ5] wake leaves registers and memory untouched
// [RQ6] reset while asleep restarts at reset vector
// [RQ7] idle stops only core and flash clocks
// [RQ8] idle wakes on any enabled interrupt
// [RQ9] idle or noise mode starts conversion
// [RQ10] noise mode stops io core flash clocks
// [RQ11] noise mode wakes only on listed sources
// [RQ12] timer two runs in noise mode if async
// [RQ13] non-idle modes wake on level interrupts only
// [RQ14] timer oscillator active only if timer async
// [RQ15] brownout sleep disable bit six resets zero
// [RQ16] detector off at entry, back at wake
// [RQ17] detector-off wake delays about 60 us
// [RQ18] software changes disable bit via timed write
// [RQ19] disable only in deep sleep modes
// [RQ20] software powers comparator down before idle
// [RQ21] 010 down 011 save 110 standby 111 ext
// [RQ22] standby modes wake within six cycles
// [RQ23] power-down wake waits fuse reset time-out
// [RQ24] halt without enable acts as plain instruction
// [RQ25] modes 100 and 101 enter no sleep
module sleep_mode_controller #(
    parameter int TIMEOUT_CYCLES  = sleep_pkg::TIMEOUT_DEFAULT,
    parameter int BOD_WAKE_CYCLES = sleep_pkg::BOD_WAKE_CYCLES
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 reset_in,
    input  wire logic                 halt_exec_in,
    input  wire logic                 sleep_enable_bit_in,
    input  wire logic [2:0]           sleep_mode_select_in,
    input  wire logic                 ctrl_wr_in,
    input  wire logic [7:0]           ctrl_wdata_in,
    input  wire logic                 brownout_sleep_disable_unlock_in,
    input  wire logic                 timer_two_async_in,
    input  wire logic                 converter_enabled_in,
    input  wire logic                 ext_osc_selected_in,
    input  wire logic                 ext_reset_in,
    input  wire logic                 wdt_reset_in,
    input  wire logic                 bod_reset_in,
    input  wire sleep_pkg::wake_src_t wake_src_in,
    output sleep_pkg::clk_gate_t      clk_gate_out,
    output logic                      asleep_out,
    output logic                      core_halt_out,
    output logic                      irq_resume_out,
    output logic                      reset_wake_out,
    output logic                      conv_start_out,
    output logic                      brownout_detector_on_out,
    output logic                      brownout_sleep_disable_out,
    output logic [2:0]                active_mode_out
);
    localparam int TW = 16;

    // external, watchdog and brownout reset inputs are asynchronous; two flops each
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    wire  [2:0] async_raw = {ext_reset_in, wdt_reset_in, bod_reset_in};

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= async_raw;
            sync2_q <= sync1_q;
        end
    end

    wire wake_reset = |sync2_q;

    sleep_pkg::sleep_state_t state_q, state_d;
    logic [2:0]  mode_q;
    logic        brownout_sleep_disable_q;
    logic        bod_off_q;
    logic        bod_on_q;
    logic [2:0]  unlock_cnt_q;
    logic        core_halt_q;
    logic        asleep_q;
    logic        irq_resume_q;
    logic        reset_wake_q;
    logic        conv_start_q;
    sleep_pkg::clk_gate_t gate_q;

    function automatic logic mode_valid(input logic [2:0] m);
        return m == sleep_pkg::MODE_IDLE || m == sleep_pkg::MODE_NOISE_RED ||
               m == sleep_pkg::MODE_PWR_DOWN || m == sleep_pkg::MODE_PWR_SAVE ||
               m == sleep_pkg::MODE_STANDBY || m == sleep_pkg::MODE_EXT_STBY;
    endfunction

    function automatic logic deep_mode(input logic [2:0] m);
        return m == sleep_pkg::MODE_PWR_DOWN || m == sleep_pkg::MODE_PWR_SAVE ||
               m == sleep_pkg::MODE_STANDBY || m == sleep_pkg::MODE_EXT_STBY;
    endfunction

    // clock domain table per mode
    function automatic sleep_pkg::clk_gate_t gates_for(input logic [2:0] m, input logic asy);
        sleep_pkg::clk_gate_t g;
        g = '0;
        unique case (m)
            sleep_pkg::MODE_IDLE: begin
                g = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, asy}; // RQ2 RQ7 RQ14
            end
            sleep_pkg::MODE_NOISE_RED: begin
                g = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, asy}; // RQ3 RQ10 RQ14
            end
            sleep_pkg::MODE_PWR_DOWN: begin
                g = '0;
            end
            sleep_pkg::MODE_PWR_SAVE: begin
                g = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, asy}; // RQ14
            end
            sleep_pkg::MODE_STANDBY: begin
                g = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
            end
            sleep_pkg::MODE_EXT_STBY: begin
                g = '{1'b0, 1'b0, 1'b0, 1'b0, asy, 1'b1, asy}; // RQ14
            end
            default: begin
                g = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            end
        endcase
        return g;
    endfunction

    // wake qualification per mode
    wire sleep_pkg::wake_src_t w = wake_src_in;
    wire common_wake = w.ext_level || w.pin_change || w.twi_match || w.wdt_irq; // RQ13
    wire idle_wake   = common_wake || w.ext_edge || w.timer_two || w.spm_ready ||
                       w.adc_done || w.other_io; // RQ8
    wire noise_wake  = common_wake || w.spm_ready || w.adc_done ||
                       (w.timer_two && timer_two_async_in); // RQ11 RQ12
    wire save_wake   = common_wake || w.timer_two;
    wire irq_wake    = (mode_q == sleep_pkg::MODE_IDLE)      ? idle_wake  :
                       (mode_q == sleep_pkg::MODE_NOISE_RED) ? noise_wake :
                       (mode_q == sleep_pkg::MODE_PWR_SAVE ||
                        mode_q == sleep_pkg::MODE_EXT_STBY)  ? save_wake  : common_wake;

    wire enter = halt_exec_in && sleep_enable_bit_in && mode_valid(sleep_mode_select_in)
                 && state_q == sleep_pkg::ST_RUN; // RQ1 RQ24 RQ25 RQ21

    // disable bit only writable while unlock window is open
    wire unlock_open = unlock_cnt_q != 3'h0;
    wire brownout_sleep_disable_write  = ctrl_wr_in && unlock_open; // RQ18

    // wake delay selection
    wire standby_like = mode_q == sleep_pkg::MODE_STANDBY || mode_q == sleep_pkg::MODE_EXT_STBY;
    wire needs_osc    = mode_q == sleep_pkg::MODE_PWR_DOWN || mode_q == sleep_pkg::MODE_PWR_SAVE;
    wire [TW-1:0] base_delay = standby_like ? TW'(sleep_pkg::STANDBY_WAKE_CYCLES) : // RQ22
                               needs_osc    ? TW'(TIMEOUT_CYCLES) : // RQ23
                                              TW'(1);
    wire [TW-1:0] wake_delay = bod_off_q && TW'(BOD_WAKE_CYCLES) > base_delay ?
                               TW'(BOD_WAKE_CYCLES) : base_delay; // RQ17

    logic tmr_load;
    logic [TW-1:0] tmr_count;
    logic tmr_busy;
    logic tmr_done;

    wake_timer #(.WIDTH(TW)) u_timer (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .load_in    (tmr_load),
        .count_in   (tmr_count),
        .busy_out   (tmr_busy),
        .done_out   (tmr_done)
    );

    wire wake_now = state_q == sleep_pkg::ST_SLEEP && irq_wake;

    always_comb begin
        state_d   = state_q;
        tmr_load  = 1'b0;
        tmr_count = wake_delay;
        unique case (state_q)
            sleep_pkg::ST_RUN: begin
                if (enter) begin
                    state_d = sleep_pkg::ST_SLEEP;
                end
            end
            sleep_pkg::ST_SLEEP: begin
                if (irq_wake) begin
                    state_d  = sleep_pkg::ST_WAKE;
                    tmr_load = 1'b1;
                end
            end
            sleep_pkg::ST_WAKE: begin
                if (tmr_done) begin
                    state_d   = sleep_pkg::ST_HOLD;
                    tmr_load  = 1'b1;
                    tmr_count = TW'(sleep_pkg::HALT_EXTRA_CYCLES); // RQ4
                end
            end
            sleep_pkg::ST_HOLD: begin
                if (tmr_done) begin
                    state_d = sleep_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = sleep_pkg::ST_RUN;
            end
        endcase
        if (wake_reset && state_q != sleep_pkg::ST_RUN) begin
            state_d  = sleep_pkg::ST_RUN; // RQ6
            tmr_load = 1'b0;
        end
    end

    wire [2:0] mode_d = enter ? sleep_mode_select_in : mode_q;
    wire sleeping_d   = state_d != sleep_pkg::ST_RUN;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q       <= sleep_pkg::ST_RUN;
            mode_q        <= sleep_pkg::MODE_IDLE;
            brownout_sleep_disable_q        <= 1'b0; // RQ15
            bod_off_q     <= 1'b0;
            unlock_cnt_q  <= 3'h0;
        end else begin
            state_q <= state_d;
            mode_q  <= mode_d;
            if (brownout_sleep_disable_unlock_in) begin
                unlock_cnt_q <= 3'(sleep_pkg::TIMED_WINDOW_CYCLES);
            end else if (unlock_open) begin
                unlock_cnt_q <= unlock_cnt_q - 3'h1;
            end
            if (brownout_sleep_disable_write) begin
                brownout_sleep_disable_q <= ctrl_wdata_in[sleep_pkg::BROWNOUT_SLEEP_DISABLE_BIT]; // RQ15 RQ18
            end
            if (enter && brownout_sleep_disable_q && deep_mode(sleep_mode_select_in)) begin
                bod_off_q <= 1'b1; // RQ16 RQ19
            end else if (wake_now || state_d == sleep_pkg::ST_RUN) begin
                bod_off_q <= 1'b0; // RQ16
            end
        end
    end

    // outputs, all registered
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            gate_q        <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            asleep_q      <= 1'b0;
            core_halt_q   <= 1'b0;
            irq_resume_q  <= 1'b0;
            reset_wake_q  <= 1'b0;
            conv_start_q  <= 1'b0;
            bod_on_q      <= 1'b1;
        end else begin
            gate_q        <= (state_d == sleep_pkg::ST_SLEEP) ? gates_for(mode_d, timer_two_async_in)
                           : '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            asleep_q      <= state_d == sleep_pkg::ST_SLEEP;
            core_halt_q   <= sleeping_d; // RQ4
            // core keeps its register file; only a resume pulse is given
            irq_resume_q  <= state_q == sleep_pkg::ST_HOLD && tmr_done && !wake_reset; // RQ4 RQ5
            reset_wake_q  <= wake_reset && state_q != sleep_pkg::ST_RUN; // RQ6
            conv_start_q  <= enter && converter_enabled_in &&
                             (sleep_mode_select_in == sleep_pkg::MODE_IDLE ||
                              sleep_mode_select_in == sleep_pkg::MODE_NOISE_RED); // RQ9
            // off from the entry edge itself, back on as soon as sleep ends
            bod_on_q      <= !((enter && brownout_sleep_disable_q && deep_mode(sleep_mode_select_in)) ||
                               (bod_off_q && state_d == sleep_pkg::ST_SLEEP)); // RQ16 RQ19
        end
    end

    assign clk_gate_out               = gate_q;
    assign asleep_out                 = asleep_q;
    assign core_halt_out              = core_halt_q;
    assign irq_resume_out             = irq_resume_q;
    assign reset_wake_out             = reset_wake_q;
    assign conv_start_out             = conv_start_q;
    assign brownout_detector_on_out   = bod_on_q;
    assign brownout_sleep_disable_out = brownout_sleep_disable_q;
    assign active_mode_out            = mode_q;
endmodule

/* logic/wake_timer.sv */
`timescale 1ns/1ns
// down counter: load a cycle count, pulse done when it reaches zero
module wake_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_in,
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] count_in,
    output logic                  busy_out,
    output logic                  done_out
);
    logic [WIDTH-1:0] cnt_q;
    logic             busy_q;

    // done is not registered: a load of n then spans exactly n cycles of the caller's state
    wire last = busy_q && (cnt_q == '0);

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else if (load_in) begin
            cnt_q  <= count_in - WIDTH'(1);
            busy_q <= 1'b1;
        end else if (last) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - WIDTH'(1);
        end
    end

    assign busy_out = busy_q;
    assign done_out = last;
endmodule

/* pkg/sleep_pkg.sv */
package sleep_pkg;
    localparam logic [2:0] MODE_IDLE      = 3'h0;
    localparam logic [2:0] MODE_NOISE_RED = 3'h1;
    localparam logic [2:0] MODE_PWR_DOWN  = 3'h2;
    localparam logic [2:0] MODE_PWR_SAVE  = 3'h3;
    localparam logic [2:0] MODE_STANDBY   = 3'h6;
    localparam logic [2:0] MODE_EXT_STBY  = 3'h7;

    localparam int BROWNOUT_SLEEP_DISABLE_BIT            = 6;
    localparam int CLK_PERIOD_NS       = 10;
    localparam int HALT_EXTRA_CYCLES   = 4;
    localparam int STANDBY_WAKE_CYCLES = 6;
    localparam int BOD_WAKE_US         = 60;
    localparam int BOD_WAKE_CYCLES     = (BOD_WAKE_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMED_WINDOW_CYCLES = 4;
    localparam int TIMEOUT_DEFAULT     = 16;

    // per-domain clock enables
    typedef struct packed {
        logic core_clk;
        logic flash_clk;
        logic io_clk;
        logic adc_clk;
        logic asy_clk;
        logic main_osc;
        logic timer_osc;
    } clk_gate_t;

    // wake sources, already qualified by their own enables
    typedef struct packed {
        logic ext_level;
        logic ext_edge;
        logic pin_change;
        logic twi_match;
        logic timer_two;
        logic spm_ready;
        logic adc_done;
        logic wdt_irq;
        logic other_io;
    } wake_src_t;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_SLEEP  = 3'b001,
        ST_WAKE   = 3'b010,
        ST_HOLD   = 3'b011
    } sleep_state_t;
endpackage

/* testbench/core_model.sv */
`timescale 1ns/1ns
// stands in for the processor core: one halt instruction per request, never while held
module core_model (
    input  wire logic clk_sys_in,
    input  wire logic reset_in,
    input  wire logic go_in,
    input  wire logic core_halt_in,
    output logic      halt_exec_out
);
    always_ff @(posedge clk_sys_in) begin
        halt_exec_out <= !reset_in && go_in && !core_halt_in;
    end
endmodule

/* testbench/sleep_mode_controller_asserts.sv */
`timescale 1ns/1ns
module sleep_mode_controller_asserts (
    input wire logic                 clk_sys_in,
    input wire logic                 reset_in,
    input wire logic                 halt_exec_in,
    input wire logic                 sleep_enable_bit_in,
    input wire logic [2:0]           sleep_mode_select_in,
    input wire logic                 converter_enabled_in,
    input wire logic                 ext_reset_in,
    input wire sleep_pkg::clk_gate_t clk_gate_out,
    input wire logic                 asleep_out,
    input wire logic                 core_halt_out,
    input wire logic                 irq_resume_out,
    input wire logic                 reset_wake_out,
    input wire logic                 conv_start_out,
    input wire logic                 brownout_detector_on_out,
    input wire logic                 brownout_sleep_disable_out,
    input wire logic [2:0]           active_mode_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    enter_on_halt_a: assert property (halt_exec_in && sleep_enable_bit_in && sleep_mode_select_in[2:1] != 2'b10
        && !core_halt_out |=> asleep_out && core_halt_out) else $error("halt with enable did not enter sleep");
    no_enable_a: assert property (halt_exec_in && !sleep_enable_bit_in && !core_halt_out |=> !asleep_out)
        else $error("halt without enable entered sleep");
    reserved_mode_a: assert property (halt_exec_in && sleep_mode_select_in[2:1] == 2'b10 && !core_halt_out
        |=> !asleep_out) else $error("reserved mode entered sleep");
    idle_clocks_a: assert property (asleep_out && active_mode_out == sleep_pkg::MODE_IDLE
        |-> clk_gate_out[6:2] == 5'b00111) else $error("idle clock gating wrong");
    noise_clocks_a: assert property (asleep_out && active_mode_out == sleep_pkg::MODE_NOISE_RED
        |-> clk_gate_out[6:3] == 4'b0001) else $error("noise mode clock gating wrong");
    bod_kept_a: assert property (asleep_out && active_mode_out[2:1] == 2'b00 |-> brownout_detector_on_out)
        else $error("detector off in shallow sleep");
    conv_start_a: assert property (halt_exec_in && sleep_enable_bit_in && sleep_mode_select_in[2:1] == 2'b00
        && converter_enabled_in && !core_halt_out |=> conv_start_out) else $error("no conversion start");
    hold_core_a: assert property ($fell(asleep_out) && !ext_reset_in |-> core_halt_out[*5])
        else $error("core released too early after wake");
    reset_wake_a: assert property (asleep_out && ext_reset_in |-> ##[1:4] reset_wake_out)
        else $error("reset did not end sleep");
    standby_wake_a: assert property ($fell(asleep_out) && $past(active_mode_out) == sleep_pkg::MODE_STANDBY
        && !brownout_sleep_disable_out && !ext_reset_in |-> ##[4:14] irq_resume_out) else $error("slow standby wake");
    bod_off_a: assert property ($rose(asleep_out) && active_mode_out[2:1] != 2'b00 && brownout_sleep_disable_out
        |-> ##[0:1] !brownout_detector_on_out) else $error("detector not switched off");
endmodule

bind sleep_mode_controller sleep_mode_controller_asserts u_asserts (.clk_sys_in, .reset_in, .halt_exec_in,
    .sleep_enable_bit_in, .sleep_mode_select_in, .converter_enabled_in, .ext_reset_in, .clk_gate_out, .asleep_out,
    .core_halt_out, .irq_resume_out, .reset_wake_out, .conv_start_out, .brownout_detector_on_out,
    .brownout_sleep_disable_out, .active_mode_out);

/* testbench/sleep_mode_controller_tb.sv */
`timescale 1ns/1ns
module sleep_mode_controller_tb;
    logic                 clk_sys_in = 1'b0;
    logic                 reset_in = 1'b1;
    logic                 go = 1'b0;
    logic                 sleep_enable_bit_in = 1'b0;
    logic [2:0]           sleep_mode_select_in = 3'h0;
    logic                 ctrl_wr_in = 1'b0;
    logic [7:0]           ctrl_wdata_in = 8'h00;
    logic                 brownout_sleep_disable_unlock_in = 1'b0;
    logic                 ext_reset_in = 1'b0;
    logic                 timer_two_async_in = 1'b1;
    logic                 converter_enabled_in = 1'b1;
    sleep_pkg::wake_src_t wake_src_in = '0;
    sleep_pkg::clk_gate_t clk_gate_out;
    logic                 halt_exec_in, asleep_out, core_halt_out, irq_resume_out, reset_wake_out;
    logic                 conv_start_out, brownout_detector_on_out, brownout_sleep_disable_out, deep;
    logic [2:0]           active_mode_out;
    int                   n, lo;
    int                   n_mismatch = 0;
    int                   cmp_count = 0;
    logic [2:0]           modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [6:0]           gates [6] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02, 7'h07};
    logic [8:0]           bad [6] = '{9'h000, 9'h081, 9'h094, 9'h084, 9'h094, 9'h084};
    logic [8:0]           good [6] = '{9'h080, 9'h004, 9'h020, 9'h010, 9'h100, 9'h002};
    int                   dly [6] = '{1, 1, 8, 8, 6, 6};

    always #5 clk_sys_in = ~clk_sys_in;

    core_model u_core_model (.clk_sys_in, .reset_in, .go_in(go), .core_halt_in(core_halt_out),
        .halt_exec_out(halt_exec_in));

    // short fuse time-out and detector restart keep the run brief
    sleep_mode_controller #(.TIMEOUT_CYCLES(8), .BOD_WAKE_CYCLES(20)) u_sleep_mode_controller (
        .clk_sys_in, .reset_in, .halt_exec_in, .sleep_enable_bit_in, .sleep_mode_select_in, .ctrl_wr_in,
        .ctrl_wdata_in, .brownout_sleep_disable_unlock_in, .timer_two_async_in, .converter_enabled_in,
        .ext_osc_selected_in(1'b1), .ext_reset_in, .wdt_reset_in(1'b0), .bod_reset_in(1'b0), .wake_src_in,
        .clk_gate_out, .asleep_out, .core_halt_out, .irq_resume_out, .reset_wake_out, .conv_start_out,
        .brownout_detector_on_out, .brownout_sleep_disable_out, .active_mode_out);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic do_halt(input logic en, input logic [2:0] m);
        sleep_enable_bit_in = en;
        sleep_mode_select_in = m;
        go = 1'b1;
        @(negedge clk_sys_in);
        go = 1'b0;
        @(negedge clk_sys_in);
    endtask

    task automatic ctrl_write(input logic unlock, input logic v);
        brownout_sleep_disable_unlock_in = unlock;
        @(negedge clk_sys_in);
        brownout_sleep_disable_unlock_in = 1'b0;
        ctrl_wr_in = 1'b1;
        ctrl_wdata_in = {1'b0, v, 6'h00};
        @(negedge clk_sys_in);
        ctrl_wr_in = 1'b0;
        @(negedge clk_sys_in);
    endtask

    // source level stays up until the core is released
    task automatic wake(input logic [8:0] src, output int cnt);
        wake_src_in = src;
        cnt = 0;
        while (irq_resume_out !== 1'b1 && cnt < 200) begin
            @(negedge clk_sys_in);
            cnt++;
        end
        wake_src_in = '0;
    endtask

    initial begin
        #100us;
        n_mismatch++;
        results();
    end

    initial begin
        repeat (4) @(negedge clk_sys_in);
        reset_in = 1'b0;
        chk({4'h0, brownout_sleep_disable_out, brownout_detector_on_out, clk_gate_out, active_mode_out},
            {4'h0, 1'b0, 1'b1, 7'h7f, 3'h0});
        do_halt(1'b0, 3'h0);
        chk(asleep_out, 1'b0);
        do_halt(1'b1, 3'h4);
        chk(asleep_out, 1'b0);
        do_halt(1'b1, 3'h5);
        chk(asleep_out, 1'b0);
        ctrl_write(1'b0, 1'b1);
        chk(brownout_sleep_disable_out, 1'b0);
        for (int p = 0; p < 2; p++) begin
            ctrl_write(1'b1, p[0]);
            chk(brownout_sleep_disable_out, p[0]);
            for (int i = 0; i < 6; i++) begin
                deep = modes[i][2:1] != 2'b00;
                do_halt(1'b1, modes[i]);
                chk({asleep_out, core_halt_out, clk_gate_out, active_mode_out},
                    {2'b11, gates[i], modes[i]});
                chk(conv_start_out, !deep);
                chk(brownout_detector_on_out, !(deep && p == 1));
                wake_src_in = bad[i];
                repeat (8) @(negedge clk_sys_in);
                chk(asleep_out, 1'b1);
                wake(good[i], n);
                // start-up, then the held cycles, then one negedge to see the registered resume
                lo = ((deep && p == 1) ? 20 : dly[i]) + sleep_pkg::HALT_EXTRA_CYCLES + 1;
                chk(16'(n), 16'(lo));
                @(negedge clk_sys_in);
                chk({core_halt_out, clk_gate_out, brownout_detector_on_out}, {1'b0, 7'h7f, 1'b1});
            end
        end
        timer_two_async_in = 1'b0;
        converter_enabled_in = 1'b0;
        do_halt(1'b1, sleep_pkg::MODE_NOISE_RED);
        chk({conv_start_out, clk_gate_out}, {1'b0, 7'h0e});
        wake_src_in = 9'h010;
        repeat (8) @(negedge clk_sys_in);
        chk(asleep_out, 1'b1);
        wake(9'h004, n);
        chk(16'(n), 16'(1 + sleep_pkg::HALT_EXTRA_CYCLES + 1));
        @(negedge clk_sys_in);
        do_halt(1'b1, sleep_pkg::MODE_PWR_DOWN);
        ext_reset_in = 1'b1;
        n = 0;
        while (reset_wake_out !== 1'b1 && n < 10) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(n < 10, 1'b1);
        @(negedge clk_sys_in);
        chk({asleep_out, irq_resume_out}, 2'b00);
        chk({reset_wake_out, core_halt_out, brownout_detector_on_out}, 3'b001);
        ext_reset_in = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        results();
    end
endmodule
